// *** ref_switch_pkg.sv ***
// constants for the reference switchover monitor
`default_nettype none
package ref_switch_pkg;
  // apb register byte offsets
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] mux_addr = 8'h04;
  localparam logic [7:0] cfg_addr = 8'h08;
  localparam logic [7:0] status_addr = 8'h0c;
  // control field positions
  localparam int mode_lo = 0;
  localparam int prim_bit = 2;
  localparam int revert_bit = 3;
  localparam int prog_bit = 4;
  localparam int gin_en_lo = 8;
  localparam int pll_on_lo = 16;
  // reset values
  localparam logic [31:0] ctrl_reset = 32'h0007_3f00;
  localparam logic [31:0] mux_reset = 32'h0000_0003;
  // switchover mode decodes
  localparam logic [1:0] mode_nonrev = 2'b10;
  localparam logic [1:0] mode_rev = 2'b11;
  // counts in clocks of the timing sources, then a source code and the bank and pll counts
  localparam logic [10:0] revert_short = 11'h008;
  localparam logic [10:0] revert_long = 11'h400;
  localparam logic [1:0] miss_limit = 2'h2;
  localparam logic [1:0] hold_cycles = 2'h2;
  localparam logic [1:0] src_ref = 2'h3;
  localparam int n_banks = 6;
  localparam int n_pll = 3;
  localparam int osc_stretch = 4;
endpackage
`default_nettype wire

// *** ref_switch_monitor.sv ***
// reference supervision, switchover and output source matrix
// ---------------------------------------------------------------
// How it works
// - any powered pll unlocked raises lock-loss
// - locked only while edges within half period
// - clock-lost when selected or both references vanish
// - time detector from oscillator if both references missing
// - mode 0x manual, 10 nonrevertive, 11 revertive
// - primary bit picks primary, other secondary
// - automatic only with crystal input primary
// - manual select pin picks reference, glitch-free
// - lock-loss held two new-clock cycles per switch
// - auto switch after primary misses two secondary cycles
// - nonrevertive switch asserts both flags two cycles
// - lock-loss stays until pll relocks
// - both references dead raises both flags
// - nonrevertive never returns; pin toggle needed
// - revert after 8 or 1024 good primary cycles
// - revertive ignores the select pin
// - unequal frequencies stay on primary unless missing
// - each bank selects a pll or reference
// - defaults drive only bank one from reference
// - latch five config pins at reset, sixth low
// - pin pairs choose config, divider bit applies
// - configuration held until supply cycles
// - programming mode maps flags to general outputs
// ---------------------------------------------------------------
`default_nettype none
module ref_switch_monitor
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reference activity, sampled in pclk
  input wire logic crystal_reference_input,
  input wire logic alternate_clock_input,
  input wire logic osc_tick,
  input wire logic source_select_pin,
  // pll lock monitors
  input wire logic [2:0] pll_phase_err,
  input wire logic [2:0] pll_feedback_edge,
  // configuration pins
  input wire logic [5:0] config_select_pin,
  input wire logic [5:0] pll_div_bits,
  // outputs
  output logic use_secondary,
  output logic lock_lost,
  output logic input_clock_lost_flag,
  output logic general_output_0,
  output logic general_output_1,
  output logic [11:0] bank_source,
  output logic [5:0] pll_config_sel,
  output logic [2:0] divider_config_select
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt, mux_r, mux_nxt;
  logic wr, rd;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  // configuration is only lost with presetn (supply cycle)
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    mux_nxt = mux_r;
    pslverr = 1'b0;
    if (psel & penable)
    begin
      unique case (paddr)
        ref_switch_pkg::ctrl_addr:
        begin
          if (wr)
            ctrl_nxt = pwdata;
        end
        ref_switch_pkg::mux_addr:
        begin
          if (wr)
            mux_nxt = {20'h0_0000, pwdata[11:0]};
        end
        ref_switch_pkg::cfg_addr,
        ref_switch_pkg::status_addr:
          pslverr = pwrite;
        default:
          pslverr = 1'b1;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= ref_switch_pkg::ctrl_reset;
      mux_r <= ref_switch_pkg::mux_reset;
    end
    else if (clk_en)
    begin
      ctrl_r <= ctrl_nxt;
      mux_r <= mux_nxt;
    end
  end
  logic [1:0] mode;
  logic prim_alt, revert_long_sel, prog_mode, auto_mode;
  logic [5:0] gin_en;
  logic [2:0] pll_on;
  assign mode = ctrl_r[ref_switch_pkg::mode_lo +: 2];
  assign prim_alt = ctrl_r[ref_switch_pkg::prim_bit];
  assign revert_long_sel = ctrl_r[ref_switch_pkg::revert_bit];
  assign prog_mode = ctrl_r[ref_switch_pkg::prog_bit];
  assign gin_en = ctrl_r[ref_switch_pkg::gin_en_lo +: 6];
  assign pll_on = ctrl_r[ref_switch_pkg::pll_on_lo +: 3];
  // auto only when the crystal input is primary
  assign auto_mode = mode[1] & ~prim_alt;
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [4:0] s1_r, s2_r, s3_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
    end
    else if (clk_en)
    begin
      s1_r <= {osc_tick, source_select_pin, alternate_clock_input,
               crystal_reference_input, 1'b0};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic xtal_edge, alt_edge, osc_edge, sel_pin;
  assign xtal_edge = s2_r[1] ^ s3_r[1];
  assign alt_edge = s2_r[2] ^ s3_r[2];
  assign osc_edge = s2_r[4] & ~s3_r[4];
  assign sel_pin = s2_r[3] & gin_en[5];
  logic prim_edge, sec_edge;
  assign prim_edge = prim_alt ? alt_edge : xtal_edge;
  assign sec_edge = prim_alt ? xtal_edge : alt_edge;
  // cycles are counted on rises, toggles only prove activity
  logic xtal_rise, alt_rise, prim_rise, sec_rise;
  assign xtal_rise = s2_r[1] & ~s3_r[1];
  assign alt_rise = s2_r[2] & ~s3_r[2];
  assign prim_rise = prim_alt ? alt_rise : xtal_rise;
  assign sec_rise = prim_alt ? xtal_rise : alt_rise;
  // ---------------------------------------------------------------
  // activity detectors
  // ---------------------------------------------------------------
  logic [1:0] prim_miss_r, prim_miss_nxt, sec_miss_r, sec_miss_nxt;
  logic [2:0] osc_cnt_r, osc_cnt_nxt;
  logic prim_dead, sec_dead, sel_dead;
  // osc gives a time base when both references stop
  always_comb
  begin
    prim_miss_nxt = prim_miss_r;
    sec_miss_nxt = sec_miss_r;
    osc_cnt_nxt = osc_cnt_r;
    if (prim_edge)
      prim_miss_nxt = 2'h0;
    else if (sec_rise && prim_miss_r != ref_switch_pkg::miss_limit)
      prim_miss_nxt = prim_miss_r + 2'h1;
    if (sec_edge)
      sec_miss_nxt = 2'h0;
    else if (prim_rise && sec_miss_r != ref_switch_pkg::miss_limit)
      sec_miss_nxt = sec_miss_r + 2'h1;
    if (prim_edge || sec_edge)
      osc_cnt_nxt = 3'h0;
    else if (osc_edge && osc_cnt_r != 3'(ref_switch_pkg::osc_stretch))
      osc_cnt_nxt = osc_cnt_r + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prim_miss_r <= 2'h0;
      sec_miss_r <= 2'h0;
      osc_cnt_r <= 3'h0;
    end
    else if (clk_en)
    begin
      prim_miss_r <= prim_miss_nxt;
      sec_miss_r <= sec_miss_nxt;
      osc_cnt_r <= osc_cnt_nxt;
    end
  end
  logic both_dead;
  assign both_dead = osc_cnt_r == 3'(ref_switch_pkg::osc_stretch);
  assign prim_dead = prim_miss_r == ref_switch_pkg::miss_limit || both_dead;
  assign sec_dead = sec_miss_r == ref_switch_pkg::miss_limit || both_dead;
  // ---------------------------------------------------------------
  // switchover state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {on_prim, on_sec, on_sec_held} sw_state_t;
  sw_state_t st_r, st_nxt;
  logic [10:0] good_r, good_nxt;
  logic pin_last_r, pin_last_nxt, switched;
  logic [10:0] revert_need;
  assign revert_need = revert_long_sel ? ref_switch_pkg::revert_long
                                       : ref_switch_pkg::revert_short;
  always_comb
  begin
    st_nxt = st_r;
    good_nxt = good_r;
    pin_last_nxt = sel_pin;
    if (prim_dead)
      good_nxt = 11'h000;
    else if (prim_rise && good_r != revert_need)
      good_nxt = good_r + 11'h001;
    unique case (st_r)
      on_prim:
      begin
        if (!auto_mode && sel_pin)
          st_nxt = on_sec;
        else if (auto_mode && prim_miss_r == ref_switch_pkg::miss_limit)
          st_nxt = mode[0] ? on_sec : on_sec_held;
      end
      on_sec:
      begin
        if (!auto_mode && !sel_pin)
          st_nxt = on_prim;
        else if (auto_mode && mode[0] && good_r == revert_need)
          st_nxt = on_prim;
      end
      on_sec_held:
      begin
        if (!auto_mode || mode[0])
          st_nxt = on_sec;
        else if (sel_pin != pin_last_r)
          st_nxt = on_prim;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= on_prim;
      good_r <= 11'h000;
      pin_last_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      good_r <= good_nxt;
      pin_last_r <= pin_last_nxt;
    end
  end
  assign switched = (st_nxt == on_prim) != (st_r == on_prim);
  assign use_secondary = st_r != on_prim;
  assign sel_dead = use_secondary ? sec_dead : prim_dead;
  // ---------------------------------------------------------------
  // lock detection and flags
  // ---------------------------------------------------------------
  logic [1:0] hold_r, hold_nxt;
  logic relock_r, relock_nxt, any_unlock, new_edge;
  logic lock_nxt, lost_nxt;
  // unpowered plls are masked so a shutdown never flags
  assign any_unlock = |(pll_on & pll_phase_err);
  assign new_edge = use_secondary ? sec_rise : prim_rise;
  always_comb
  begin
    hold_nxt = hold_r;
    relock_nxt = relock_r;
    if (switched)
    begin
      // first rise after the switch only opens a whole cycle
      hold_nxt = ref_switch_pkg::hold_cycles + 2'h1;
      relock_nxt = auto_mode;
    end
    else
    begin
      if (new_edge && hold_r != 2'h0)
        hold_nxt = hold_r - 2'h1;
      if (relock_r && hold_r == 2'h0 && !any_unlock
          && |(pll_on & pll_feedback_edge))
        relock_nxt = 1'b0;
    end
    lock_nxt = any_unlock || hold_nxt != 2'h0 || relock_nxt || both_dead;
    lost_nxt = sel_dead || both_dead ||
               (st_nxt == on_sec_held && hold_nxt != 2'h0) ||
               (auto_mode && mode[0] && st_nxt == on_sec);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_r <= 2'h0;
      relock_r <= 1'b0;
      lock_lost <= 1'b0;
      input_clock_lost_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      hold_r <= hold_nxt;
      relock_r <= relock_nxt;
      lock_lost <= lock_nxt;
      input_clock_lost_flag <= lost_nxt;
    end
  end
  assign general_output_0 = prog_mode & lock_lost;
  assign general_output_1 = prog_mode & input_clock_lost_flag;
  // ---------------------------------------------------------------
  // configuration select and matrix
  // ---------------------------------------------------------------
  logic cfg_taken_r;
  logic [5:0] cfg_latch_r, cfg_pins;
  // pins caught on the first enabled edge after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_taken_r <= 1'b0;
      cfg_latch_r <= 6'h00;
    end
    else if (clk_en && !cfg_taken_r)
    begin
      cfg_taken_r <= 1'b1;
      cfg_latch_r <= {1'b0, config_select_pin[4:0]};
    end
  end
  assign cfg_pins = prog_mode ? cfg_latch_r
                              : (config_select_pin & gin_en);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_config_sel <= 6'h00;
      divider_config_select <= 3'h0;
      bank_source <= 12'h000;
      prdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pll_config_sel <= cfg_pins;
      for (int i = 0; i < ref_switch_pkg::n_pll; i++)
        divider_config_select[i] <= pll_div_bits[2*i +: 2] != 2'h0
          && cfg_pins[2*i +: 2] != 2'h0;
      bank_source <= mux_r[11:0];
      if (rd)
      begin
        unique case (paddr)
          ref_switch_pkg::ctrl_addr: prdata <= ctrl_r;
          ref_switch_pkg::mux_addr: prdata <= mux_r;
          ref_switch_pkg::cfg_addr:
            prdata <= {26'h000_0000, cfg_pins};
          ref_switch_pkg::status_addr:
            prdata <= {26'h000_0000, both_dead, prim_dead, sec_dead,
                       input_clock_lost_flag, lock_lost, use_secondary};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_unlock;
    @(posedge pclk) disable iff (!presetn)
    clk_en && |(pll_on & pll_phase_err) |=> lock_lost;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock missed");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    clk_en && switched |=> lock_lost;
  endproperty
  a_hold: assert property (p_hold) else $error("no switch hold");
  property p_both;
    @(posedge pclk) disable iff (!presetn)
    clk_en && both_dead |=> lock_lost && input_clock_lost_flag;
  endproperty
  a_both: assert property (p_both) else $error("both dead");
  property p_nonrev;
    @(posedge pclk) disable iff (!presetn)
    st_r == on_sec_held && clk_en && sel_pin == pin_last_r
      && auto_mode && !mode[0] |=> st_r == on_sec_held;
  endproperty
  a_nonrev: assert property (p_nonrev) else $error("reverted");
  property p_manual_only_xtal;
    @(posedge pclk) disable iff (!presetn)
    prim_alt && clk_en |=> st_r != on_sec_held;
  endproperty
  a_manual_only_xtal: assert property (p_manual_only_xtal)
    else $error("auto on alt");
  property p_gout;
    @(posedge pclk) disable iff (!presetn)
    !prog_mode |-> !general_output_0 && !general_output_1;
  endproperty
  a_gout: assert property (p_gout) else $error("gout leak");
  property p_cfg6;
    @(posedge pclk) disable iff (!presetn)
    cfg_taken_r |-> !cfg_latch_r[5];
  endproperty
  a_cfg6: assert property (p_cfg6) else $error("pin six set");
  property p_revert;
    @(posedge pclk) disable iff (!presetn)
    clk_en && st_r == on_sec && auto_mode && mode[0]
      && good_r == revert_need |=> st_r == on_prim;
  endproperty
  a_revert: assert property (p_revert) else $error("no revert");
  c_switch: cover property (@(posedge pclk) switched);
  c_held: cover property (@(posedge pclk) st_r == on_sec_held);
  c_both: cover property (@(posedge pclk) both_dead);
endmodule
`default_nettype wire

// *** ref_pair_model.sv ***
// model of the two reference sources, oscillator and select pin
`default_nettype none
module ref_pair_model
#(
  parameter int prim_half = 2,
  parameter int sec_half = 3
)
(
  // clock
  input wire logic pclk,
  // controls from the bench
  input wire logic prim_run,
  input wire logic sec_run,
  input wire logic pin_req,
  // reference side
  output logic crystal_reference_input,
  output logic alternate_clock_input,
  output logic osc_tick,
  output logic source_select_pin
);
  int pc = 0;
  int sc = 0;
  initial
  begin
    crystal_reference_input = 1'b0;
    alternate_clock_input = 1'b0;
    osc_tick = 1'b0;
    source_select_pin = 1'b0;
  end
  // a stopped source parks at its last level, as a dead oscillator does
  always @(posedge pclk)
  begin
    pc = (pc + 1) % prim_half;
    sc = (sc + 1) % sec_half;
    if (prim_run && pc == 0)
      crystal_reference_input <= ~crystal_reference_input;
    if (sec_run && sc == 0)
      alternate_clock_input <= ~alternate_clock_input;
    osc_tick <= ~osc_tick;
    source_select_pin <= pin_req;
  end
endmodule
`default_nettype wire

// *** test_redundant_ref_switchover_monitor.sv ***
// self-checking bench for the reference switchover monitor
`default_nettype none
module test_redundant_ref_switchover_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] a_ctrl = ref_switch_pkg::ctrl_addr;
  localparam logic [7:0] a_mux = ref_switch_pkg::mux_addr;
  logic pclk = 0;
  logic presetn = 0;
  logic clk_en = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ref_a, ref_b, osc, pin;
  logic prim_run = 1;
  logic sec_run = 1;
  logic pin_req = 0;
  logic [2:0] phase_err = 3'h0;
  logic [2:0] fb_edge = 3'h0;
  logic [5:0] cfg_pins = 6'h00;
  logic [5:0] div_bits = 6'h00;
  logic use_sec, lock_lost, clk_lost, go0, go1;
  logic [11:0] bank_source;
  logic [5:0] cfg_sel;
  logic [2:0] div_sel;
  logic [31:0] rd, v;
  logic err;
  logic [31:0] exp_reg [4];
  logic [31:0] seed = 32'h0000_0049;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  always #25 pclk = ~pclk;
  always @(posedge pclk) fb_edge <= ~fb_edge;
  ref_switch_monitor u_ref_switch_monitor (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_reference_input(ref_a),
    .alternate_clock_input(ref_b), .osc_tick(osc),
    .source_select_pin(pin), .pll_phase_err(phase_err),
    .pll_feedback_edge(fb_edge), .config_select_pin(cfg_pins),
    .pll_div_bits(div_bits), .use_secondary(use_sec),
    .lock_lost(lock_lost), .input_clock_lost_flag(clk_lost),
    .general_output_0(go0), .general_output_1(go1),
    .bank_source(bank_source), .pll_config_sel(cfg_sel),
    .divider_config_select(div_sel));
  ref_pair_model u_ref_pair_model (.pclk(pclk), .prim_run(prim_run),
    .sec_run(sec_run), .pin_req(pin_req), .crystal_reference_input(ref_a),
    .alternate_clock_input(ref_b), .osc_tick(osc),
    .source_select_pin(pin));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic final_report();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // zero-wait slave, but the master still waits for pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    exp_reg[a[3:2]] = d;
    chk1(err, 1'b0);
  endtask
  task automatic rdchk(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
    chk32(rd, exp_reg[a[3:2]]);
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? use_sec : s == 1 ? lock_lost : clk_lost;
  endfunction
  // sampled before the edge's own updates land
  task automatic wait_on(input int s, input logic val, input int lim);
    int k;
    k = 0;
    while (sig(s) !== val && k < lim)
    begin
      @(posedge pclk);
      k++;
    end
    chk1(sig(s), val);
  endtask
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    exp_reg[0] = ref_switch_pkg::ctrl_reset;
    exp_reg[1] = ref_switch_pkg::mux_reset;
    v = xs();
    cfg_pins = v[5:0];
    div_bits = v[11:6];
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk32({20'h0, bank_source}, 32'h0000_0003);
    chk32({26'h0, cfg_sel}, {26'h0, cfg_pins});
    for (int i = 0; i < 3; i++)
      chk1(div_sel[i], |div_bits[2*i +: 2] && |cfg_pins[2*i +: 2]);
    rdchk(a_ctrl);
    rdchk(a_mux);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk1(err, 1'b1);
    apb(1'b1, ref_switch_pkg::status_addr, 32'hffff_ffff);
    chk1(err, 1'b1);
    // every bank code, then random routing
    for (int i = 0; i < 4; i++)
    begin
      v = i == 0 ? 32'h0000_0e4e : i == 1 ? 32'h0000_01b1 : xs() & 32'hfff;
      wr(a_mux, v);
      rdchk(a_mux);
      repeat (2) @(posedge pclk);
      chk32({20'h0, bank_source}, v);
    end
    // a write with the enable low must not land
    clk_en <= 1'b0;
    apb(1'b1, a_mux, 32'h0000_0abc);
    clk_en <= 1'b1;
    rdchk(a_mux);
    wait_on(1, 1'b0, 400);
    phase_err <= 3'h1;
    wait_on(1, 1'b1, 20);
    wr(a_ctrl, 32'h0007_3f10);
    @(posedge pclk);
    chk1(go0, 1'b1);
    chk1(go1, clk_lost);
    @(posedge pclk);
    chk32({26'h0, cfg_sel}, {27'h0, cfg_pins[4:0]});
    phase_err <= 3'h0;
    wr(a_ctrl, 32'h0006_3f00);
    wait_on(1, 1'b0, 400);
    phase_err <= 3'h1;
    repeat (10) @(posedge pclk);
    chk1(lock_lost, 1'b0);
    phase_err <= 3'h0;
    wr(a_ctrl, 32'h0007_3f00);
    pin_req <= 1'b1;
    wait_on(0, 1'b1, 100);
    n = 0;
    repeat (20)
    begin
      @(posedge pclk);
      n += lock_lost;
    end
    chk1(n >= 12, 1'b1);
    pin_req <= 1'b0;
    wait_on(0, 1'b0, 100);
    wr(a_ctrl, 32'h0007_3f06);
    sec_run <= 1'b0;
    repeat (60) @(posedge pclk);
    chk1(use_sec, 1'b0);
    chk1(clk_lost, 1'b1);
    sec_run <= 1'b1;
    // let the stale miss count clear before auto mode starts
    repeat (10) @(posedge pclk);
    wr(a_ctrl, 32'h0007_3f02);
    prim_run <= 1'b0;
    wait_on(0, 1'b1, 100);
    @(posedge pclk);
    chk1(lock_lost, 1'b1);
    chk1(clk_lost, 1'b1);
    prim_run <= 1'b1;
    wait_on(1, 1'b0, 400);
    repeat (100) @(posedge pclk);
    chk1(use_sec, 1'b1);
    pin_req <= 1'b1;
    repeat (10) @(posedge pclk);
    pin_req <= 1'b0;
    wait_on(0, 1'b0, 100);
    for (int j = 0; j < 2; j++)
    begin
      wr(a_ctrl, j == 0 ? 32'h0007_3f03 : 32'h0007_3f0b);
      pin_req <= 1'b1;
      repeat (30) @(posedge pclk);
      chk1(use_sec, 1'b0);
      prim_run <= 1'b0;
      wait_on(0, 1'b1, 100);
      prim_run <= 1'b1;
      repeat (j == 0 ? 20 : 3000) @(posedge pclk);
      chk1(use_sec, 1'b1);
      wait_on(0, 1'b0, j == 0 ? 200 : 3000);
      wait_on(2, 1'b0, 50);
      pin_req <= 1'b0;
    end
    prim_run <= 1'b0;
    sec_run <= 1'b0;
    wait_on(2, 1'b1, 200);
    chk1(lock_lost, 1'b1);
    apb(1'b0, ref_switch_pkg::status_addr, 32'h0000_0000);
    chk32(rd, 32'h0000_003e);
    apb(1'b0, ref_switch_pkg::cfg_addr, 32'h0000_0000);
    chk32(rd, {26'h0, cfg_pins});
    final_report();
  end
endmodule
`default_nettype wire
